// ===== core/sdc_prog_host.sv
`timescale 1ns/100ps
`include "sdc_defines.svh"

module sdc_prog_host
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // Link to the synthesizer
   sdc_link_if.host         link
);

   // Software registers and sequencer
   logic [`SDC_FRAC_W-1:0]            frac_ff, nxt_frac;
   logic [`SDC_FB_W-`SDC_FRAC_W-1:0]  whole_ff, nxt_whole;
   logic [`SDC_FAST_W-1:0]            fast_ff, nxt_fast;
   logic [`SDC_SLOW_W-1:0]            slow_ff, nxt_slow;
   sdc_grade_type                     grade_ff, nxt_grade;
   logic                              reject_ff, nxt_reject;
   logic                              done_ff, nxt_done;
   sdc_state_type                     state_ff, nxt_state;
   logic [2:0]                        idx_ff, nxt_idx;
   logic                              wr_en_ff, nxt_wr_en;
   logic [7:0]                        addr_ff, nxt_addr;
   logic [7:0]                        data_ff, nxt_data;
   logic [31:0]                       prdata_ff, nxt_prdata;
   logic                              pslverr_ff, nxt_pslverr;
   logic                              pready_ff;
   logic [`SDC_FB_W-1:0]              fb;
   logic                              setup, wr_acc, mapped, go;

   // Full legality check on the requested settings
   function automatic logic legal(input logic [`SDC_FB_W-1:0] f, input logic [`SDC_FAST_W-1:0] h,
                                  input logic [`SDC_SLOW_W-1:0] s, input sdc_grade_type g);
      logic [`SDC_WIDE_W-1:0] fv, vmax, fmax;
      logic [`SDC_SLOW_W-1:0] e;
      e     = (s > `SDC_SLOW_MAX_EXP) ? `SDC_SLOW_MAX_EXP : s;
      fv    = `SDC_WIDE_W'(f) * `SDC_WIDE_W'(`SDC_XTAL_HZ);
      vmax  = `SDC_WIDE_W'((g == SDC_GRADE_A) ? `SDC_VCO_MAX_A_HZ : `SDC_VCO_MAX_BC_HZ);
      fmax  = `SDC_WIDE_W'((g == SDC_GRADE_A) ? `SDC_FOUT_MAX_A :
                           (g == SDC_GRADE_B) ? `SDC_FOUT_MAX_B : `SDC_FOUT_MAX_C);
      legal = (f >= `SDC_FB_MIN) && (f <= `SDC_FB_MAX)
           && (h >= `SDC_FAST_MIN) && (h <= `SDC_FAST_MAX)
           && ((h <= `SDC_FAST_ODD_MAX) || !h[0])
           && (fv >= (`SDC_WIDE_W'(`SDC_VCO_MIN_HZ) << `SDC_FRAC_W))
           && (fv <= (vmax << `SDC_FRAC_W))
           && (fv <= ((fmax * (`SDC_WIDE_W'(h) << e)) << `SDC_FRAC_W))
           && (g != 2'b11);
   endfunction

   // Byte sent at each step of the load
   function automatic logic [7:0] send_byte(input logic [2:0] i, input logic [`SDC_FB_W-1:0] f,
                                           input logic [`SDC_FAST_W-1:0] h, input logic [`SDC_SLOW_W-1:0] s);
      logic [47:0] fw;
      fw = {5'h00, f};
      if (i == 3'h0) send_byte = h[7:0];
      else if (i == 3'h1) send_byte = {1'b0, s, 1'b0, h[10:8]};
      else send_byte = fw[(i - 3'h2)*8 +: 8];
   endfunction

   assign fb     = {whole_ff, frac_ff};
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && pready_ff;
   assign mapped = paddr <= `SDC_APB_STATUS && paddr[1:0] == 2'b00;
   assign go     = wr_acc && paddr == `SDC_APB_CTRL && pwdata[`SDC_CTRL_GO];

   // Register writes; settings frozen while a load runs
   always_comb begin
      nxt_frac  = frac_ff;
      nxt_whole = whole_ff;
      nxt_fast  = fast_ff;
      nxt_slow  = slow_ff;
      nxt_grade = grade_ff;
      if (wr_acc && state_ff == SDC_IDLE) begin
         unique case (paddr)
            `SDC_APB_CTRL:     nxt_grade = sdc_grade_type'(pwdata[`SDC_CTRL_GRADE_LSB +: 2]);
            `SDC_APB_FB_FRAC:  nxt_frac  = pwdata;
            `SDC_APB_FB_WHOLE: nxt_whole = pwdata[`SDC_FB_W-`SDC_FRAC_W-1:0];
            `SDC_APB_FAST:     nxt_fast  = pwdata[`SDC_FAST_W-1:0];
            `SDC_APB_SLOW:     nxt_slow  = pwdata[`SDC_SLOW_W-1:0];
            default:           nxt_frac  = frac_ff;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         frac_ff  <= '0;
         whole_ff <= '0;
         fast_ff  <= '0;
         slow_ff  <= '0;
         grade_ff <= SDC_GRADE_A;
      end else begin
         frac_ff  <= nxt_frac;
         whole_ff <= nxt_whole;
         fast_ff  <= nxt_fast;
         slow_ff  <= nxt_slow;
         grade_ff <= nxt_grade;
      end
   end

   // Sequencer: check, then write eight bytes back to back
   always_comb begin
      nxt_state  = state_ff;
      nxt_idx    = idx_ff;
      nxt_reject = reject_ff && !(go && state_ff == SDC_IDLE);
      nxt_done   = done_ff && !(go && state_ff == SDC_IDLE);
      nxt_wr_en  = 1'b0;
      nxt_addr   = addr_ff;
      nxt_data   = data_ff;
      unique case (state_ff)
         SDC_IDLE: if (go) nxt_state = SDC_CHECK;
         SDC_CHECK: begin
            nxt_idx = 3'h0;
            if (legal(fb, fast_ff, slow_ff, grade_ff)) begin
               nxt_state = SDC_SEND;
            end else begin
               nxt_reject = 1'b1;
               nxt_state  = SDC_IDLE;
            end
         end
         SDC_SEND: begin
            nxt_wr_en = 1'b1;
            nxt_addr  = (idx_ff < 3'h2) ? `SDC_ADDR_FAST_LO + 8'(idx_ff)
                                        : `SDC_ADDR_FB_FIRST + 8'(idx_ff) - 8'h02;
            nxt_data  = send_byte(idx_ff, fb, fast_ff, slow_ff);
            nxt_idx   = idx_ff + 3'h1;
            if (idx_ff == `SDC_NUM_BYTES) begin
               nxt_state = SDC_IDLE;
               nxt_done  = 1'b1;
            end
         end
         default: nxt_state = SDC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff  <= SDC_IDLE;
         idx_ff    <= '0;
         reject_ff <= 1'b0;
         done_ff   <= 1'b0;
         wr_en_ff  <= 1'b0;
         addr_ff   <= '0;
         data_ff   <= '0;
      end else begin
         state_ff  <= nxt_state;
         idx_ff    <= nxt_idx;
         reject_ff <= nxt_reject;
         done_ff   <= nxt_done;
         wr_en_ff  <= nxt_wr_en;
         addr_ff   <= nxt_addr;
         data_ff   <= nxt_data;
      end
   end

   // Read data and error captured in the setup cycle
   always_comb begin
      nxt_prdata  = prdata_ff;
      nxt_pslverr = pslverr_ff;
      if (setup) begin
         nxt_pslverr = !mapped;
         nxt_prdata  = '0;
         if (!pwrite) begin
            unique case (paddr)
               `SDC_APB_CTRL:     nxt_prdata = {29'h0, grade_ff, 1'b0};
               `SDC_APB_FB_FRAC:  nxt_prdata = frac_ff;
               `SDC_APB_FB_WHOLE: nxt_prdata = {21'h0, whole_ff};
               `SDC_APB_FAST:     nxt_prdata = {21'h0, fast_ff};
               `SDC_APB_SLOW:     nxt_prdata = {29'h0, slow_ff};
               `SDC_APB_STATUS:   nxt_prdata = {28'h0, link.out_clk, done_ff, reject_ff,
                                                state_ff != SDC_IDLE};
               default:           nxt_prdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
         pready_ff  <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
         pready_ff  <= 1'b1;
      end
   end

   assign prdata       = prdata_ff;
   assign pslverr      = pslverr_ff;
   assign pready       = pready_ff;
   assign link.wr_en   = wr_en_ff;
   assign link.addr    = addr_ff;
   assign link.wr_data = data_ff;

endmodule // sdc_prog_host

// ===== core/sdc_defines.svh
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Field widths of the divider chain
`define SDC_FB_W          43
`define SDC_FRAC_W        32
`define SDC_FAST_W        11
`define SDC_SLOW_W        3
`define SDC_BYTE_W        8
`define SDC_ACC_W         64
`define SDC_MOD_STEPS     16

// Byte map of the device registers
`define SDC_ADDR_FAST_LO  8'h17
`define SDC_ADDR_PACKED   8'h18
`define SDC_ADDR_FB_FIRST 8'h1A
`define SDC_ADDR_FB_LAST  8'h1F
`define SDC_PACK_SLOW_LSB 4
`define SDC_PACK_FAST_LSB 0
`define SDC_FAST_LO_W     8

// Settings held after reset
`define SDC_RST_FB        43'h047_E756_E62A
`define SDC_RST_FAST      11'h046
`define SDC_RST_SLOW      3'h0
`define SDC_SLOW_MAX_EXP  3'h5

// Legal ranges seen by the programming end
`define SDC_FB_MIN        43'h03C_0000_0000
`define SDC_FB_MAX        43'h7FD_FFFF_FFFF
`define SDC_FAST_MIN      11'h005
`define SDC_FAST_MAX      11'h7FE
`define SDC_FAST_ODD_MAX  11'h021
`define SDC_XTAL_HZ       28'h918_7DC0
`define SDC_VCO_MIN_HZ    36'h2_83BA_EC00
`define SDC_VCO_MAX_A_HZ  36'h2_E9C4_3B22
`define SDC_VCO_MAX_BC_HZ 36'h2_D793_BCD0
`define SDC_FOUT_MAX_A    32'h5968_2F00
`define SDC_FOUT_MAX_B    32'h2FAF_0800
`define SDC_FOUT_MAX_C    32'h135F_1B40
`define SDC_WIDE_W        80

// APB map of the programming end
`define SDC_APB_CTRL      8'h00
`define SDC_APB_FB_FRAC   8'h04
`define SDC_APB_FB_WHOLE  8'h08
`define SDC_APB_FAST      8'h0C
`define SDC_APB_SLOW      8'h10
`define SDC_APB_STATUS    8'h14
`define SDC_CTRL_GO       0
`define SDC_CTRL_GRADE_LSB 1
`define SDC_NUM_BYTES     3'h7

`endif

// ===== core/sdc_pkg.sv
package sdc_pkg;
   // Speed grade selection
   typedef enum logic [1:0] {
      SDC_GRADE_A = 2'b00,
      SDC_GRADE_B = 2'b01,
      SDC_GRADE_C = 2'b10
   } sdc_grade_type;

   // Programming sequencer states
   typedef enum logic [1:0] {
      SDC_IDLE  = 2'b00,
      SDC_CHECK = 2'b01,
      SDC_SEND  = 2'b10
   } sdc_state_type;
endpackage

// ===== core/sdc_link_if.sv
`timescale 1ns/100ps
interface sdc_link_if;
   // Register write and read-back
   logic       wr_en;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   // Synthesized clock
   logic       out_clk;

   modport dev  (input wr_en, addr, wr_data, output rd_data, out_clk);
   modport host (output wr_en, addr, wr_data, input rd_data, out_clk);
endinterface

// ===== core/sdc_synth_dev.sv
`timescale 1ns/100ps
`include "sdc_defines.svh"

module sdc_synth_dev
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   // Link to the programming end
   sdc_link_if.dev                      link,
   // User side
   output      logic                    synth_clk,
   output      logic [`SDC_FB_W-1:0]    fb_setting,
   output      logic [`SDC_FAST_W-1:0]  fast_setting,
   output      logic [`SDC_SLOW_W-1:0]  slow_setting
);

   // Divider settings, one register per field so a rewrite
   // of one leaves the others alone; mixed values between
   // the bytes of one burst last only a few cycles
   logic [`SDC_FB_W-1:0]   feedback_ratio_ff;
   logic [`SDC_FB_W-1:0]   nxt_feedback_ratio;
   logic [`SDC_FAST_W-1:0] fast_output_ratio_ff;
   logic [`SDC_FAST_W-1:0] nxt_fast_output_ratio;
   logic [`SDC_SLOW_W-1:0] slow_output_exponent_ff;
   logic [`SDC_SLOW_W-1:0] nxt_slow_output_exponent;
   // Synthesis model state
   // Phase in 1/2^32 VCO cycles; 64 bits hold any period
   logic [`SDC_ACC_W-1:0]  phase_ff;
   logic [`SDC_ACC_W-1:0]  nxt_phase;
   logic                   out_clk_ff;
   logic                   nxt_out_clk;
   logic [`SDC_BYTE_W-1:0] rd_data_ff;
   logic [`SDC_BYTE_W-1:0] nxt_rd_data;
   // Derived values
   logic [`SDC_ACC_W-1:0]  period;
   logic [`SDC_ACC_W-1:0]  phase_sum;
   logic [`SDC_ACC_W-1:0]  phase_mod;

   // Slow exponent clamped so 6 and 7 behave as 5
   // Kept in one place so every user of the ratio agrees
   function automatic logic [`SDC_SLOW_W-1:0] slow_exp(input logic [`SDC_SLOW_W-1:0] code);
      slow_exp = (code > `SDC_SLOW_MAX_EXP) ? `SDC_SLOW_MAX_EXP : code;
   endfunction

   // Total output ratio as an unsigned product
   // Slow ratio is a power of two: a shift, no multiplier
   function automatic logic [`SDC_ACC_W-1:0] total_ratio(input logic [`SDC_FAST_W-1:0] fast,
                                                        input logic [`SDC_SLOW_W-1:0] code);
      logic [`SDC_ACC_W-1:0] wide;
      // Zero-extended: the ratio is never negative
      wide        = {{(`SDC_ACC_W-`SDC_FAST_W){1'b0}}, fast};
      total_ratio = wide << slow_exp(code);
   endfunction

   // Remainder by restoring subtraction, bounded number of steps
   // Sixteen steps cover any legal setting, also after a shrink;
   // one combinational pass trades area for a one-cycle result
   function automatic logic [`SDC_ACC_W-1:0] mod_reduce(input logic [`SDC_ACC_W-1:0] value,
                                                       input logic [`SDC_ACC_W-1:0] modulus);
      logic [`SDC_ACC_W-1:0] rest;
      rest = value;
      for (int i = `SDC_MOD_STEPS - 1; i >= 0; i--) begin
         if (rest >= (modulus << i)) begin
            rest = rest - (modulus << i);
         end
      end
      mod_reduce = rest;
   endfunction

   // Register writes over the link, each field held until rewritten
   // Address 19h and unmapped addresses change nothing
   always_comb begin
      // Hold every field unless its byte is written
      nxt_feedback_ratio       = feedback_ratio_ff;
      nxt_fast_output_ratio    = fast_output_ratio_ff;
      nxt_slow_output_exponent = slow_output_exponent_ff;
      if (link.wr_en) begin
         if (link.addr == `SDC_ADDR_FAST_LO) begin
            // Low byte alone; high bits wait for the packed byte
            nxt_fast_output_ratio[`SDC_FAST_LO_W-1:0] = link.wr_data;
         end
         if (link.addr == `SDC_ADDR_PACKED) begin
            // Bits 7 and 3 are unused and dropped
            // Exponent and fast high bits move together
            nxt_slow_output_exponent = link.wr_data[`SDC_PACK_SLOW_LSB +: `SDC_SLOW_W];
            nxt_fast_output_ratio[`SDC_FAST_W-1:`SDC_FAST_LO_W] =
               link.wr_data[`SDC_PACK_FAST_LSB +: (`SDC_FAST_W-`SDC_FAST_LO_W)];
         end
         for (int b = 0; b <= `SDC_ADDR_FB_LAST - `SDC_ADDR_FB_FIRST; b++) begin
            if (link.addr == `SDC_ADDR_FB_FIRST + 8'(b)) begin
               // Bytes arrive lowest first; whole part settles last
               // Top byte carries only the three highest whole bits
               if (b == `SDC_ADDR_FB_LAST - `SDC_ADDR_FB_FIRST) begin
                  nxt_feedback_ratio[`SDC_FB_W-1:`SDC_FB_W-3] = link.wr_data[2:0];
               end else begin
                  nxt_feedback_ratio[b*`SDC_BYTE_W +: `SDC_BYTE_W] = link.wr_data;
               end
            end
         end
      end
   end

   // Reset to a legal setting so the output runs before any load
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         feedback_ratio_ff       <= `SDC_RST_FB;
         fast_output_ratio_ff    <= `SDC_RST_FAST;
         slow_output_exponent_ff <= `SDC_RST_SLOW;
      end else begin
         feedback_ratio_ff       <= nxt_feedback_ratio;
         fast_output_ratio_ff    <= nxt_fast_output_ratio;
         slow_output_exponent_ff <= nxt_slow_output_exponent;
      end
   end

   // Phase model: one clock is one reference period. The VCO advances by
   // the feedback ratio in 1/2^32 VCO cycles; the output period is the
   // total ratio in VCO cycles. Output faster than half the clock aliases.
   // Limitation: the level is right only on average; single
   // VCO cycles are never seen, which suffices for rate and
   // duty, not for jitter.
   always_comb begin
      // Output period in 1/2^32 VCO cycles
      period      = total_ratio(fast_output_ratio_ff, slow_output_exponent_ff) << `SDC_FRAC_W;
      phase_sum   = phase_ff + {{(`SDC_ACC_W-`SDC_FB_W){1'b0}}, feedback_ratio_ff};
      // Reduction also copes with a period shrinking mid-run
      phase_mod   = mod_reduce(phase_sum, period);
      nxt_phase   = phase_mod;
      // High in the first half of the period; for odd ratios the half
      // falls on a half VCO cycle, which keeps the duty at 50%
      nxt_out_clk = (phase_mod << 1) < period;
   end

   // Phase and output level both reset to zero, so the output starts low
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phase_ff   <= '0;
         out_clk_ff <= 1'b0;
      end else begin
         phase_ff   <= nxt_phase;
         out_clk_ff <= nxt_out_clk;
      end
   end

   // Read-back of the addressed byte, one cycle behind the address
   // Unused bits and unmapped addresses read as zero, so
   // the host never sees stale data from another byte
   always_comb begin
      nxt_rd_data = '0;
      if (link.addr == `SDC_ADDR_FAST_LO) begin
         nxt_rd_data = fast_output_ratio_ff[`SDC_FAST_LO_W-1:0];
      end
      if (link.addr == `SDC_ADDR_PACKED) begin
         // Same packing as the write side
         nxt_rd_data[`SDC_PACK_SLOW_LSB +: `SDC_SLOW_W] = slow_output_exponent_ff;
         nxt_rd_data[`SDC_PACK_FAST_LSB +: (`SDC_FAST_W-`SDC_FAST_LO_W)] =
            fast_output_ratio_ff[`SDC_FAST_W-1:`SDC_FAST_LO_W];
      end
      for (int b = 0; b <= `SDC_ADDR_FB_LAST - `SDC_ADDR_FB_FIRST; b++) begin
         if (link.addr == `SDC_ADDR_FB_FIRST + 8'(b)) begin
            if (b == `SDC_ADDR_FB_LAST - `SDC_ADDR_FB_FIRST) begin
               // Top byte: three whole bits, upper bits zero
               nxt_rd_data[2:0] = feedback_ratio_ff[`SDC_FB_W-1:`SDC_FB_W-3];
            end else begin
               nxt_rd_data = feedback_ratio_ff[b*`SDC_BYTE_W +: `SDC_BYTE_W];
            end
         end
      end
   end

   // Read-back register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   // Outputs straight from flip-flops
   // Both clock outputs share one flop, so they never skew
   assign link.rd_data  = rd_data_ff;
   assign link.out_clk  = out_clk_ff;
   assign synth_clk     = out_clk_ff;
   assign fb_setting    = feedback_ratio_ff;
   assign fast_setting  = fast_output_ratio_ff;
   assign slow_setting  = slow_output_exponent_ff;

endmodule // sdc_synth_dev

// ===== test/sdc_link_monitor.sv
`timescale 1ns/100ps
`include "sdc_defines.svh"

module sdc_link_monitor (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // Link signals
   input wire logic       wr_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       out_clk
);
   logic [39:0]            hist_ff;
   logic [42:0]            fb_seen;
   logic [10:0]            fast_seen;
   logic [`SDC_WIDE_W-1:0] vco_prod;
   logic [10:0]            run_ff;
   logic                   lvl_ff;

   // Cycles the output level has stood; a stuck divider runs long
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         run_ff <= '0;
         lvl_ff <= 1'b0;
      end else begin
         lvl_ff <= out_clk;
         run_ff <= (out_clk != lvl_ff) ? 11'h000 : run_ff + 11'h001;
      end
   end

   // Last five bytes sent, oldest lowest
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         hist_ff <= '0;
      else if (wr_en)
         hist_ff <= {wr_data, hist_ff[39:8]};
   end

   // Values as they complete on the wire; product kept wide so no bit is lost
   assign fb_seen   = {wr_data[2:0], hist_ff};
   assign fast_seen = {wr_data[2:0], hist_ff[39:32]};
   assign vco_prod  = `SDC_WIDE_W'(fb_seen) * `SDC_WIDE_W'(`SDC_XTAL_HZ);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Steps of one load
   sequence burst_s;
      wr_en [*8] ##1 !wr_en;
   endsequence
   sequence addr_walk_s;
      addr == 8'h17 ##1 addr == 8'h18 ##1 addr == 8'h1A ##1 addr == 8'h1B
      ##1 addr == 8'h1C ##1 addr == 8'h1D ##1 addr == 8'h1E ##1 addr == 8'h1F;
   endsequence

   burst_len_a: assert property ($rose(wr_en) |-> burst_s)
      else $error("link burst is not eight bytes");
   byte_order_a: assert property ($rose(wr_en) |-> addr_walk_s)
      else $error("link byte order wrong");
   packed_gaps_a: assert property (wr_en && addr == 8'h18 |-> !wr_data[7] && !wr_data[3])
      else $error("unused packed bits set");
   fb_top_a: assert property (wr_en && addr == 8'h1F |-> wr_data[7:3] == 5'h00)
      else $error("feedback wider than 43 bits");
   fast_range_a: assert property (wr_en && addr == 8'h18 |->
      fast_seen >= `SDC_FAST_MIN && fast_seen <= `SDC_FAST_MAX)
      else $error("fast ratio out of range");
   fast_parity_a: assert property (wr_en && addr == 8'h18 && fast_seen > `SDC_FAST_ODD_MAX |->
      !fast_seen[0])
      else $error("odd fast ratio above 33");
   fb_range_a: assert property (wr_en && addr == 8'h1F |->
      fb_seen >= `SDC_FB_MIN && fb_seen <= `SDC_FB_MAX)
      else $error("feedback ratio out of range");
   vco_band_a: assert property (wr_en && addr == 8'h1F |-> vco_prod >= {`SDC_VCO_MIN_HZ, 32'h0000_0000}
      && vco_prod <= {`SDC_VCO_MAX_A_HZ, 32'hFFFF_FFFF})
      else $error("vco outside band");
   rd_hold_a: assert property (!wr_en && !$past(wr_en) && !$past(wr_en, 2) && $stable(addr) |=>
      $stable(rd_data))
      else $error("read-back changed without write");
   clk_alive_a: assert property (run_ff < 11'h3E8)
      else $error("synthesized clock stuck");
   rd_echo_a: assert property (wr_en && addr == 8'h1F ##1 !wr_en |=>
      rd_data == {5'h00, $past(wr_data[2:0], 2)})
      else $error("top feedback byte not read back");
endmodule // sdc_link_monitor

// ===== test/tb_top.sv
`timescale 1ns/100ps
`include "sdc_defines.svh"

module tb_top import sdc_pkg::*;;
   logic        sys_clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        synth_clk;
   logic [42:0] fb_setting;
   logic [10:0] fast_setting;
   logic [2:0]  slow_setting;
   logic [65:0] exp_q[$];
   logic [65:0] note;
   logic [31:0] rnd;
   logic [31:0] rd_last;
   int          errors;
   int          samples_checked;
   int          cycles;
   // {whole, fast, slow, grade, legal}; bad entries probe the fast range, parity, vco band, grade A fout and grade code limits
   logic [27:0] cases [16] = '{
      {11'h048, 11'h7FE, 3'h5, 2'h0, 1'b1}, {11'h048, 11'h7FE, 3'h6, 2'h1, 1'b1},
      {11'h048, 11'h7FE, 3'h7, 2'h2, 1'b1}, {11'h051, 11'h7FE, 3'h5, 2'h0, 1'b1},
      {11'h048, 11'h021, 3'h5, 2'h2, 1'b1}, {11'h048, 11'h3E8, 3'h4, 2'h1, 1'b1},
      {11'h048, 11'h022, 3'h5, 2'h0, 1'b1}, {11'h048, 11'h005, 3'h3, 2'h2, 1'b1},
      {11'h048, 11'h023, 3'h5, 2'h0, 1'b0}, {11'h048, 11'h004, 3'h5, 2'h0, 1'b0},
      {11'h048, 11'h7FF, 3'h5, 2'h0, 1'b0}, {11'h046, 11'h7FE, 3'h5, 2'h0, 1'b0},
      {11'h052, 11'h7FE, 3'h5, 2'h0, 1'b0}, {11'h051, 11'h7FE, 3'h5, 2'h1, 1'b0},
      {11'h048, 11'h7FE, 3'h5, 2'h3, 1'b0}, {11'h048, 11'h005, 3'h0, 2'h0, 1'b0}};

   sdc_link_if link_bus ();
   sdc_prog_host u_sdc_prog_host (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link_bus));
   sdc_synth_dev u_sdc_synth_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_bus),
      .synth_clk(synth_clk), .fb_setting(fb_setting), .fast_setting(fast_setting),
      .slow_setting(slow_setting));
   sdc_link_monitor u_sdc_link_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .wr_en(link_bus.wr_en),
      .addr(link_bus.addr), .wr_data(link_bus.wr_data), .rd_data(link_bus.rd_data),
      .out_clk(link_bus.out_clk));

   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("Checks made %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // One APB transfer; a read leaves its note before the access edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] mask, input logic [32:0] exp);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      if (!wr)
         exp_q.push_back({mask, exp});
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd_last = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // High and low run of one output period
   task automatic measure(input logic [63:0] exp_p);
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      while (synth_clk !== 1'b0)
         @(posedge sys_clk);
      while (synth_clk !== 1'b1)
         @(posedge sys_clk);
      while (synth_clk === 1'b1) begin
         hi++;
         @(posedge sys_clk);
      end
      while (synth_clk === 1'b0) begin
         lo++;
         @(posedge sys_clk);
      end
      check("clock period", 64'(64'(hi + lo) - exp_p <= 1), 64'h1);
      check("duty cycle", 64'(2 * hi + 2 >= hi + lo && 2 * hi <= hi + lo + 2), 64'h1);
   endtask

   // Load one setting; frac kept below one half so whole alone decides the vco band
   task automatic load_case(input logic [27:0] c);
      logic [31:0] frac;
      logic [42:0] fb_old;
      logic [10:0] fast_old;
      logic [2:0]  slow_old;
      logic [2:0]  eff;
      int          n;
      rnd = lfsr_next(rnd);
      frac = rnd & 32'h7FFF_FFFF;
      fb_old = fb_setting;
      fast_old = fast_setting;
      slow_old = slow_setting;
      eff = (c[5:3] > 3'h5) ? 3'h5 : c[5:3];
      apb(1'b1, `SDC_APB_FB_FRAC, frac, '0, '0);
      apb(1'b1, `SDC_APB_FB_WHOLE, 32'(c[27:17]), '0, '0);
      apb(1'b1, `SDC_APB_FAST, 32'(c[16:6]), '0, '0);
      apb(1'b1, `SDC_APB_SLOW, 32'(c[5:3]), '0, '0);
      apb(1'b1, `SDC_APB_CTRL, 32'({c[2:1], 1'b1}), '0, '0);
      apb(1'b1, `SDC_APB_FAST, 32'h0000_0007, '0, '0);
      n = 0;
      do begin
         apb(1'b0, `SDC_APB_STATUS, '0, '0, '0);
         n++;
      end while (rd_last[2:1] == 2'b00 && n < 40);
      apb(1'b0, `SDC_APB_STATUS, '0, 33'h1_0000_0007, c[0] ? 33'h0_0000_0004 : 33'h0_0000_0002);
      check("fb setting", 64'(fb_setting), c[0] ? 64'({c[27:17], frac}) : 64'(fb_old));
      check("fast setting", 64'(fast_setting), c[0] ? 64'(c[16:6]) : 64'(fast_old));
      check("slow setting", 64'(slow_setting), c[0] ? 64'(c[5:3]) : 64'(slow_old));
      if (c[0] && (32'(c[16:6]) << eff) >= 32'(c[27:17]) * 8)
         measure(((64'(c[16:6]) << eff) << 32) / 64'({c[27:17], frac}));
   endtask

   // Read results against the oldest note
   always @(posedge sys_clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         note = exp_q.pop_front();
         check("apb read", 64'({pslverr, prdata} & note[65:33]), 64'(note[32:0]));
      end
   end

   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rnd = 32'hD92E_86F6;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check("fb reset", 64'(fb_setting), 64'(`SDC_RST_FB));
      check("fast reset", 64'(fast_setting), 64'(`SDC_RST_FAST));
      apb(1'b0, `SDC_APB_STATUS, '0, 33'h1_0000_0007, '0);
      apb(1'b0, 8'h18, '0, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
      apb(1'b0, 8'h06, '0, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
      foreach (cases[i])
         load_case(cases[i]);
      tally_and_finish();
   end
endmodule // tb_top
